// file: scs_asserts.sv
// bound checker for the system clock source select block
`timescale 1ns/1ps
module scs_asserts
    import scs_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        direct_clock_input_pin,
    input wire logic        oscillator_input_pin,
    input wire logic        internal_clock_src,
    input wire logic        wakeup_clock_src,
    input wire logic        sys_clk_out,
    input wire logic        loop_enable,
    input wire logic        loop_locked
);
    logic [1:0] sel_r, sel_nxt;
    logic [1:0] lc_r, lc_nxt;
    logic [9:0] k1_r, k1_nxt;
    logic [2:0] quiet_r, quiet_nxt;
    logic       ref_lvl;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    // shadow of the configuration; quiet counts cycles since the last configuration write, holding at 7
    always_comb begin
        sel_nxt = sel_r;
        lc_nxt = lc_r;
        k1_nxt = k1_r;
        quiet_nxt = (quiet_r == 3'h7) ? quiet_r : quiet_r + 3'h1;
        if (reg_wr && reg_addr == SCS_OFS_SYS_CFG && reg_wdata[1:0] != 2'b01)
            sel_nxt = reg_wdata[1:0];
        if (reg_wr && reg_addr == SCS_OFS_LOOP_CFG)
            lc_nxt = reg_wdata[1:0];
        if (reg_wr && reg_addr == SCS_OFS_PRESC)
            k1_nxt = reg_wdata[9:0];
        // unmapped low addresses also restart it, which only costs coverage
        if (reg_wr && reg_addr <= SCS_OFS_PRESC)
            quiet_nxt = 3'h0;
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sel_r <= SCS_SEL_RST;
            lc_r <= {1'b0, SCS_BYPASS_RST};
            k1_r <= 10'h000;
            quiet_r <= 3'h0;
        end else begin
            sel_r <= sel_nxt;
            lc_r <= lc_nxt;
            k1_r <= k1_nxt;
            quiet_r <= quiet_nxt;
        end
    end
    assign ref_lvl = lc_r[1] ? internal_clock_src : oscillator_input_pin;
    ////////////////////////////////////////////////////////////////////////////////
    // register port and clock path relations
    sequence s_rsvd_wr;
        reg_wr && reg_addr == SCS_OFS_SYS_CFG && reg_wdata[1:0] == 2'b01;
    endsequence
    sequence s_sel_rd;
        reg_rd && reg_addr == SCS_OFS_SYS_CFG;
    endsequence
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside read answer");
    a_read_source: assert property (s_sel_rd |=> reg_rdata == {30'h0, $past(sel_r)})
        else $error("source select read back wrong");
    a_reserved_keep: assert property (s_rsvd_wr ##2 s_sel_rd |=>
        reg_rdata[1:0] == $past(sel_r, 3)) else $error("reserved select changed source");
    a_status_flags: assert property (reg_rd && reg_addr == SCS_OFS_STATUS |=>
        reg_rdata[15:0] == {14'h0, $past(loop_enable), $past(loop_locked)})
        else $error("status flags wrong");
    a_loop_enable: assert property (quiet_r >= 3'h2 |->
        loop_enable == (sel_r == 2'b10 && !lc_r[0])) else $error("loop enable wrong");
    a_direct_follow: assert property (quiet_r >= 3'h4 && sel_r == 2'b11 |->
        sys_clk_out == $past(direct_clock_input_pin, 3)) else $error("direct drive broken");
    a_presc_follow: assert property (quiet_r >= 3'h4 && sel_r == 2'b10 && lc_r[0] &&
        k1_r == 10'h0 |-> sys_clk_out == $past(ref_lvl, 3)) else $error("divide by one broken");
    a_wakeup_follow: assert property (quiet_r >= 3'h4 && sel_r == 2'b00 |->
        sys_clk_out == $past(wakeup_clock_src, 3)) else $error("wakeup source broken");
    // lock flag clears while the loop is off
    a_lock_idle: assert property (!loop_enable |=> !loop_locked)
        else $error("lock flag set with loop off");
    // a vco carry needs several adds, so the loop output never toggles twice in a row
    sequence s_loop_mode;
        quiet_r >= 3'h4 && sel_r == 2'b10 && !lc_r[0];
    endsequence
    a_loop_smooth: assert property (s_loop_mode ##0 $changed(sys_clk_out) |=>
        $stable(sys_clk_out)) else $error("loop output changed too fast");
endmodule : scs_asserts

bind scs_top scs_asserts u_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .direct_clock_input_pin(direct_clock_input_pin),
    .oscillator_input_pin(oscillator_input_pin), .internal_clock_src(internal_clock_src),
    .wakeup_clock_src(wakeup_clock_src), .sys_clk_out(sys_clk_out),
    .loop_enable(loop_enable), .loop_locked(loop_locked)
);

// file: scs_pkg.sv
// constants, field layout and mode codes for the system clock source select block
// Summary of operation
// - source select 11 passes the synchronised direct clock pin, three clk_sys cycles late, as the system clock.
// - prescaler mode with a divide factor of one follows its input level, like direct drive.
// - source select 10 with vco bypass set divides the oscillator or internal source by K1.
// - K1 is the divide field plus one and reaches 1024 at most.
// - source select 10 with vco bypass clear enables the loop and uses its output clock.
// - the loop factor is N over P times K2, each the matching field plus one.
// - the loop reference is selectable between the oscillator pin and the internal source.
// - while locking, the loop frequency moves by one small step per reference tick.
// - the loop output is the vco divided by K2, so T output cycles span K2 times T vco cycles.
// - vco band 00 and 01 pick two rate ranges, and band codes 1x are reserved.
// - source select 00 runs the system clock from the wakeup source.
package scs_pkg;
    // register byte offsets
    localparam logic [7:0] SCS_OFS_SYS_CFG  = 8'h00;
    localparam logic [7:0] SCS_OFS_LOOP_CFG = 8'h04;
    localparam logic [7:0] SCS_OFS_PRESC    = 8'h08;
    localparam logic [7:0] SCS_OFS_STATUS   = 8'h0c;

    // loop_config field positions
    localparam int SCS_LC_BYPASS  = 0;
    localparam int SCS_LC_REFSEL  = 1;
    localparam int SCS_LC_BAND_LO = 2;
    localparam int SCS_LC_P_LO    = 4;
    localparam int SCS_LC_N_LO    = 8;
    localparam int SCS_LC_K2_LO   = 16;

    // field widths
    localparam int SCS_P_W  = 4;
    localparam int SCS_N_W  = 7;
    localparam int SCS_K2_W = 7;
    localparam int SCS_K1_W = 10;
    localparam int SCS_INC_W = 16;

    // reset values
    localparam logic [1:0]  SCS_SEL_RST     = 2'b00;
    localparam logic        SCS_BYPASS_RST  = 1'b1;
    localparam logic [31:0] SCS_LOOP_RST    = 32'h0000_0001;

    // vco increment limits per band (scaled model of the two rate ranges)
    localparam logic [15:0] SCS_B0_MIN = 16'h0400;
    localparam logic [15:0] SCS_B0_MAX = 16'h1000;
    localparam logic [15:0] SCS_B1_MIN = 16'h0c00;
    localparam logic [15:0] SCS_B1_MAX = 16'h2000;
    localparam logic [15:0] SCS_INC_STEP = 16'h0001;

    // source select codes
    typedef enum logic [1:0] {
        SCS_SRC_WAKEUP = 2'b00,
        SCS_SRC_RSVD   = 2'b01,
        SCS_SRC_DERIV  = 2'b10,
        SCS_SRC_DIRECT = 2'b11
    } scs_src_t;
endpackage : scs_pkg

// file: scs_top.sv
// system clock source select: source mux, prescaler, loop model and register port
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module scs_top
    import scs_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    input  wire logic        direct_clock_input_pin,
    input  wire logic        oscillator_input_pin,
    input  wire logic        internal_clock_src,
    input  wire logic        wakeup_clock_src,
    output logic             sys_clk_out,
    output logic             loop_enable,
    output logic             loop_locked
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: bit 0 direct, 1 oscillator, 2 internal, 3 wakeup
    logic [3:0] pin_s1_r;
    logic [3:0] pin_s2_r;
    logic [3:0] pin_s3_r;
    logic [3:0] pin_s1_nxt;
    logic [3:0] pin_s2_nxt;
    logic [3:0] pin_s3_nxt;

    always_comb begin
        pin_s1_nxt = {wakeup_clock_src, internal_clock_src,
                      oscillator_input_pin, direct_clock_input_pin};
        pin_s2_nxt = pin_s1_r;
        pin_s3_nxt = pin_s2_r;  // previous level, for edge detection only
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_r <= 4'h0;
            pin_s2_r <= 4'h0;
            pin_s3_r <= 4'h0;
        end else begin
            pin_s1_r <= pin_s1_nxt;
            pin_s2_r <= pin_s2_nxt;
            pin_s3_r <= pin_s3_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register file
    scs_src_t                 active_sel_r;
    scs_src_t                 active_sel_nxt;
    logic [31:0]              loop_cfg_r;
    logic [31:0]              loop_cfg_nxt;
    logic [SCS_K1_W-1:0]      k1_field_r;
    logic [SCS_K1_W-1:0]      k1_field_nxt;
    logic [31:0]              rdata_r;
    logic [31:0]              rdata_nxt;
    logic [1:0]               band_r;
    logic [1:0]               band_nxt;
    logic                     lock_r;
    logic                     loop_en_r;
    logic [SCS_INC_W-1:0]     inc_r;

    // config fields
    logic                     bypass;
    logic                     ref_sel;
    logic [SCS_P_W-1:0]       p_field;
    logic [SCS_N_W-1:0]       n_field;
    logic [SCS_K2_W-1:0]      k2_field;

    assign bypass   = loop_cfg_r[SCS_LC_BYPASS];
    assign ref_sel  = loop_cfg_r[SCS_LC_REFSEL];
    assign p_field  = loop_cfg_r[SCS_LC_P_LO +: SCS_P_W];
    assign n_field  = loop_cfg_r[SCS_LC_N_LO +: SCS_N_W];
    assign k2_field = loop_cfg_r[SCS_LC_K2_LO +: SCS_K2_W];

    // register writes and read mux, read data one cycle after the strobe
    always_comb begin
        active_sel_nxt = active_sel_r;
        loop_cfg_nxt   = loop_cfg_r;
        k1_field_nxt   = k1_field_r;
        band_nxt       = band_r;
        rdata_nxt      = 32'h0000_0000;
        if (reg_wr) begin
            case (reg_addr)
                SCS_OFS_SYS_CFG: begin
                    if (scs_src_t'(reg_wdata[1:0]) != SCS_SRC_RSVD) begin
                        active_sel_nxt = scs_src_t'(reg_wdata[1:0]);
                    end
                end
                SCS_OFS_LOOP_CFG: begin
                    loop_cfg_nxt = reg_wdata;
                    if (!reg_wdata[SCS_LC_BAND_LO + 1]) begin
                        band_nxt = reg_wdata[SCS_LC_BAND_LO +: 2];
                    end
                end
                // ten-bit field, K1 up to 1024
                SCS_OFS_PRESC: k1_field_nxt = reg_wdata[SCS_K1_W-1:0];
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                SCS_OFS_SYS_CFG:  rdata_nxt = {30'h0, active_sel_r};
                SCS_OFS_LOOP_CFG: rdata_nxt = {loop_cfg_r[31:4], band_r, loop_cfg_r[1:0]};
                SCS_OFS_PRESC:    rdata_nxt = {22'h0, k1_field_r};
                SCS_OFS_STATUS:   rdata_nxt = {inc_r, 14'h0, loop_en_r, lock_r};
                default:          rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            active_sel_r <= scs_src_t'(SCS_SEL_RST);
            loop_cfg_r   <= SCS_LOOP_RST;
            k1_field_r   <= '0;
            band_r       <= 2'b00;
            rdata_r      <= 32'h0000_0000;
        end else begin
            active_sel_r <= active_sel_nxt;
            loop_cfg_r   <= loop_cfg_nxt;
            k1_field_r   <= k1_field_nxt;
            band_r       <= band_nxt;
            rdata_r      <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // prescaler path, counts reference rising edges
    logic                 ref_lvl;
    logic                 ref_prev;
    logic                 ref_rise;
    logic [SCS_K1_W-1:0]  k1_cnt_r;
    logic [SCS_K1_W-1:0]  k1_cnt_nxt;
    logic [SCS_K1_W:0]    k1_half;
    logic                 presc_lvl;

    // reference from oscillator pin or internal source
    assign ref_lvl  = ref_sel ? pin_s2_r[2] : pin_s2_r[1];
    assign ref_prev = ref_sel ? pin_s3_r[2] : pin_s3_r[1];
    assign ref_rise = ref_lvl & ~ref_prev;
    assign k1_half  = ({1'b0, k1_field_r} + 11'h001) >> 1;

    always_comb begin
        k1_cnt_nxt = k1_cnt_r;
        if (ref_rise) begin
            k1_cnt_nxt = (k1_cnt_r >= k1_field_r) ? '0 : k1_cnt_r + 1'b1;
        end
        // factor one follows input duty cycle
        if (k1_field_r == '0) begin
            presc_lvl = ref_lvl;
        end else begin
            presc_lvl = ({1'b0, k1_cnt_r} < k1_half);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            k1_cnt_r <= '0;
        end else begin
            k1_cnt_r <= k1_cnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // loop model: input divider, vco accumulator, frequency lock, output divider
    logic [SCS_P_W-1:0]     p_cnt_r;
    logic [SCS_P_W-1:0]     p_cnt_nxt;
    logic [SCS_INC_W-1:0]   acc_r;
    logic [SCS_INC_W-1:0]   acc_nxt;
    logic [SCS_INC_W-1:0]   inc_nxt;
    logic                   vco_lvl_r;
    logic                   vco_lvl_nxt;
    logic [SCS_N_W:0]       vco_cnt_r;
    logic [SCS_N_W:0]       vco_cnt_nxt;
    logic [SCS_K2_W-1:0]    k2_cnt_r;
    logic [SCS_K2_W-1:0]    k2_cnt_nxt;
    logic                   loop_lvl_r;
    logic                   loop_lvl_nxt;
    logic                   lock_nxt;
    logic                   loop_en_nxt;
    logic                   ref_tick;
    logic                   half_edge;
    logic                   vco_rise;
    logic [SCS_N_W:0]       n_target;
    logic [SCS_INC_W-1:0]   inc_min;
    logic [SCS_INC_W-1:0]   inc_max;
    logic [SCS_INC_W:0]     acc_sum;

    assign inc_min  = band_r[0] ? SCS_B1_MIN : SCS_B0_MIN;
    assign inc_max  = band_r[0] ? SCS_B1_MAX : SCS_B0_MAX;
    // N is the field plus one
    assign n_target = {1'b0, n_field} + 8'h01;
    assign acc_sum  = {1'b0, acc_r} + {1'b0, inc_r};
    assign half_edge = acc_sum[SCS_INC_W];
    assign vco_rise  = half_edge & ~vco_lvl_r;
    // reference divided by P before comparison
    assign ref_tick  = ref_rise && (p_cnt_r >= p_field);

    always_comb begin
        // loop runs only in derived mode with bypass clear
        loop_en_nxt = (active_sel_r == SCS_SRC_DERIV) && !bypass;
        p_cnt_nxt   = p_cnt_r;
        acc_nxt     = acc_r;
        inc_nxt     = inc_r;
        vco_lvl_nxt = vco_lvl_r;
        vco_cnt_nxt = vco_cnt_r;
        k2_cnt_nxt  = k2_cnt_r;
        loop_lvl_nxt = loop_lvl_r;
        lock_nxt    = lock_r;
        if (!loop_en_r) begin
            // idle loop restarts from the low band edge
            p_cnt_nxt   = '0;
            acc_nxt     = '0;
            inc_nxt     = inc_min;
            vco_lvl_nxt = 1'b0;
            vco_cnt_nxt = '0;
            k2_cnt_nxt  = '0;
            loop_lvl_nxt = 1'b0;
            lock_nxt    = 1'b0;
        end else begin
            acc_nxt = acc_sum[SCS_INC_W-1:0];
            if (ref_rise) begin
                p_cnt_nxt = ref_tick ? '0 : p_cnt_r + 1'b1;
            end
            if (half_edge) begin
                vco_lvl_nxt = ~vco_lvl_r;
                // toggle every K2 half cycles, period K2 vco cycles
                if (k2_cnt_r >= k2_field) begin
                    k2_cnt_nxt   = '0;
                    loop_lvl_nxt = ~loop_lvl_r;
                end else begin
                    k2_cnt_nxt = k2_cnt_r + 1'b1;
                end
            end
            if (vco_rise && (vco_cnt_r != '1)) begin
                vco_cnt_nxt = vco_cnt_r + 1'b1;
            end
            if (ref_tick) begin
                vco_cnt_nxt = '0;
                lock_nxt    = (vco_cnt_r == n_target);
                // one small step per tick, never a jump
                if (vco_cnt_r < n_target) begin
                    if (inc_r < inc_max) inc_nxt = inc_r + SCS_INC_STEP;
                end else if (vco_cnt_r > n_target) begin
                    if (inc_r > inc_min) inc_nxt = inc_r - SCS_INC_STEP;
                end
            end
            // band change pulls rate back inside range one step per cycle
            if (inc_r > inc_max) inc_nxt = inc_r - SCS_INC_STEP;
            if (inc_r < inc_min) inc_nxt = inc_r + SCS_INC_STEP;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            p_cnt_r    <= '0;
            acc_r      <= '0;
            inc_r      <= SCS_B0_MIN;
            vco_lvl_r  <= 1'b0;
            vco_cnt_r  <= '0;
            k2_cnt_r   <= '0;
            loop_lvl_r <= 1'b0;
            lock_r     <= 1'b0;
            loop_en_r  <= 1'b0;
        end else begin
            p_cnt_r    <= p_cnt_nxt;
            acc_r      <= acc_nxt;
            inc_r      <= inc_nxt;
            vco_lvl_r  <= vco_lvl_nxt;
            vco_cnt_r  <= vco_cnt_nxt;
            k2_cnt_r   <= k2_cnt_nxt;
            loop_lvl_r <= loop_lvl_nxt;
            lock_r     <= lock_nxt;
            loop_en_r  <= loop_en_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // system clock source mux, registered so the output is glitch free
    logic sys_clk_r;
    logic sys_clk_nxt;

    always_comb begin
        case (active_sel_r)
            // direct pin at its own rate and duty
            SCS_SRC_DIRECT: sys_clk_nxt = pin_s2_r[0];
            SCS_SRC_DERIV:  sys_clk_nxt = bypass ? presc_lvl : loop_lvl_r;
            // wakeup source, no external clock needed
            SCS_SRC_WAKEUP: sys_clk_nxt = pin_s2_r[3];
            default:        sys_clk_nxt = sys_clk_r;  // not reachable, see write path
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sys_clk_r <= 1'b0;
        end else begin
            sys_clk_r <= sys_clk_nxt;
        end
    end

    assign sys_clk_out = sys_clk_r;
    assign loop_enable = loop_en_r;
    assign loop_locked = lock_r;
    assign reg_rdata   = rdata_r;

endmodule : scs_top

// file: test_system_clock_source_select.sv
// self-checking testbench for the system clock source select block
`timescale 1ns/1ps
module test_system_clock_source_select import scs_pkg::*;;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [3:0]  pins = 4'h0;
    logic        sys_clk_out, loop_enable, loop_locked;
    logic        rd_d = 1'b0;
    logic        rnd_on = 1'b1;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic [7:0]  adr_q[$];
    integer      seed = 81;
    integer      error_cnt = 0;
    integer      compares = 0;

    scs_top u_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .direct_clock_input_pin(pins[3]), .oscillator_input_pin(pins[2]),
        .internal_clock_src(pins[1]), .wakeup_clock_src(pins[0]),
        .sys_clk_out(sys_clk_out), .loop_enable(loop_enable), .loop_locked(loop_locked)
    );
    ////////////////////////////////////////////////////////////////////////////////
    // clock, source pins (random, or a clean oscillator square wave) and watchdog
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (rnd_on)
            pins <= 4'($random(seed));
        else
            pins[2] <= ~pins[2];
    end
    initial begin
        #2_000_000;
        error_cnt++;
        close_out();
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic close_out;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : close_out
    // one-cycle write; the strobe drops at the next edge, so calls never collide
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    // read with the expected word noted for the monitor
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        adr_q.push_back(a);
        @(posedge clk_sys);
        reg_rd <= 1'b0;
    endtask : rd
    // counts output rises over n oscillator rises at divide field k1f
    task automatic presc_run(input logic [9:0] k1f, input integer n);
        integer rises;
        integer want;
        logic   prev;
        rises = 0;
        want = n / (k1f + 1);
        prev = 1'b1;
        wr(SCS_OFS_PRESC, {22'h0, k1f});
        repeat (8) @(posedge clk_sys);
        repeat (2 * n) begin
            @(negedge clk_sys);
            if (sys_clk_out === 1'b1 && prev === 1'b0)
                rises++;
            prev = sys_clk_out;
        end
        check("prescaler rises", 32'(rises >= want - 1 && rises <= want + 1), 32'h1);
    endtask : presc_run
    ////////////////////////////////////////////////////////////////////////////////
    // read answer stands only in the cycle after the strobe
    always @(posedge clk_sys) rd_d <= reg_rd;
    always @(negedge clk_sys) begin
        if (rd_d)
            check($sformatf("reg %h", adr_q.pop_front()), reg_rdata & msk_q.pop_front(),
                  exp_q.pop_front());
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] v, e;
        logic [1:0]  cur, band;
        logic [1:0]  codes [4];
        integer      tg;
        logic        sp;
        codes = '{2'h3, 2'h1, 2'h0, 2'h2};
        cur = 2'h0;
        band = 2'h0;
        tg = 0;
        sp = 1'b0;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(SCS_OFS_SYS_CFG, 32'h0, 32'hffff_ffff);
        rd(SCS_OFS_LOOP_CFG, SCS_LOOP_RST, 32'hffff_ffff);
        rd(SCS_OFS_PRESC, 32'h0, 32'hffff_ffff);
        rd(SCS_OFS_STATUS, 32'h0, 32'h0000_ffff);
        // loop off after reset: both loop flags low
        @(negedge clk_sys);
        check("loop enable", 32'(loop_enable), 32'h0);
        check("loop locked", 32'(loop_locked), 32'h0);
        // random loop fields; reserved band codes leave the band alone
        for (int i = 0; i < 8; i++) begin
            v = $random(seed);
            e = v;
            if (v[3])
                e[3:2] = band;
            else
                band = v[3:2];
            wr(SCS_OFS_LOOP_CFG, v);
            rd(SCS_OFS_LOOP_CFG, e, 32'hffff_ffff);
        end
        // unmapped place and read-only status
        wr(8'h10, 32'hffff_ffff);
        rd(8'h10, 32'h0, 32'hffff_ffff);
        wr(SCS_OFS_STATUS, 32'hffff_ffff);
        rd(SCS_OFS_STATUS, 32'h0, 32'h0000_ffff);
        wr(SCS_OFS_LOOP_CFG, 32'h0000_0001);
        for (int i = 0; i < 4; i++) begin
            wr(SCS_OFS_SYS_CFG, {30'h0, codes[i]});
            if (codes[i] != 2'h1)
                cur = codes[i];
            rd(SCS_OFS_SYS_CFG, {30'h0, cur}, 32'hffff_ffff);
            repeat (16) @(posedge clk_sys);
        end
        // prescaler on a clean square wave, boundary factors included
        rnd_on <= 1'b0;
        presc_run(10'h000, 40);
        presc_run(10'h002, 60);
        presc_run(10'h3ff, 3072);
        rnd_on <= 1'b1;
        // loop mode entered from the slow prescaler setting, internal reference
        wr(SCS_OFS_LOOP_CFG, 32'h0001_0306);
        repeat (4) @(posedge clk_sys);
        rd(SCS_OFS_STATUS, 32'h0000_0002, 32'h0000_0002);
        wr(SCS_OFS_LOOP_CFG, 32'h0001_030e);
        rd(SCS_OFS_LOOP_CFG, 32'h0001_0306, 32'hffff_ffff);
        // band one rate limits bound the loop output toggles over 200 cycles
        for (int i = 0; i < 200; i++) begin
            @(negedge clk_sys);
            if (i > 0 && sys_clk_out !== sp)
                tg++;
            sp = sys_clk_out;
        end
        check("loop output toggles", 32'(tg >= 2 && tg <= 20), 32'h1);
        check("loop enable", 32'(loop_enable), 32'h1);
        wr(SCS_OFS_SYS_CFG, 32'h0000_0001);
        rd(SCS_OFS_STATUS, 32'h0000_0002, 32'h0000_0002);
        repeat (4) @(posedge clk_sys);
        close_out();
    end
endmodule : test_system_clock_source_select
